// ---- design/mrb_pkg.sv ----
// constants and types shared by the microcore register backdoor
package mrb_pkg;
  // microcore instruction codes seen on the instruction port
  localparam logic [3:0] OP_LD_ADDR = 4'h1;
  localparam logic [3:0] OP_LD_DATA = 4'h2;
  localparam logic [3:0] OP_BD_READ = 4'h3;
  localparam logic [3:0] OP_BD_WRITE = 4'h4;
  localparam logic [3:0] OP_ST_WORD = 4'h5;
  localparam logic [3:0] OP_ST_BIT = 4'h6;
  localparam logic [3:0] OP_OFS_COMP = 4'h7;
  localparam logic [3:0] OP_GAIN = 4'h8;
  localparam logic [3:0] OP_ADC = 4'h9;
  localparam logic [3:0] OP_DCDC = 4'ha;
  localparam logic [3:0] OP_EOA = 4'hb;
  // low address bytes of device registers with special handling
  localparam logic [7:0] A_HS_DRAIN = 8'h8a;
  localparam logic [7:0] A_HS_SRC = 8'h8b;
  localparam logic [7:0] A_LS_DRAIN_A = 8'h8c;
  localparam logic [7:0] A_LS_DRAIN_B = 8'h8d;
  localparam logic [7:0] A_HS_SLEW = 8'h8e;
  localparam logic [7:0] A_LS_SLEW = 8'h8f;
  localparam logic [7:0] A_BIAS = 8'ha0;
  localparam logic [7:0] A_FILT_12 = 8'ha1;
  localparam logic [7:0] A_FILT_34L = 8'ha2;
  localparam logic [7:0] A_FILT_4H4NEG = 8'ha3;
  localparam logic [7:0] A_BOOST_FILT = 8'h9d;
  localparam logic [7:0] A_DAC_FIRST = 8'h40;
  localparam logic [7:0] A_DAC_LAST = 8'h45;
  localparam logic [7:0] A_BOOST_DAC = 8'h9b;
  // field layout of the filtered registers
  localparam int THR_W = 3;
  localparam int SLEW_W = 2;
  localparam int NUM_HS = 5;
  localparam int NUM_LS = 7;
  localparam int LS_A_N = 5;
  localparam int FILT_W = 8;
  localparam int CONV_LS_IDX = 6;
  // operand fields of the instructions
  localparam int BIT_VAL = 4;
  localparam int EOA_AUTO = 1;
  localparam int EOA_SEL_LO = 2;
  localparam int GAIN_W = 2;
  // threshold converter indices: first four, fourth high, negative
  localparam int CONV_N = 6;
  localparam int CONV_4L = 3;
  localparam int CONV_4H = 4;
  localparam int CONV_NEG = 5;
  // avalon byte offsets
  localparam logic [3:0] R_ADDR = 4'h0;
  localparam logic [3:0] R_DATA = 4'h4;
  localparam logic [3:0] R_STATUS = 4'h8;
  localparam logic [3:0] R_CTRL = 4'hc;
  localparam int CTRL_CLR_ZERO = 10;
  // reset values
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [1:0] GAIN_RST = 2'h0;
  // backdoor sequencer states
  typedef enum logic [2:0] {
    MRB_IDLE = 3'b001,
    MRB_XFER = 3'b010,
    MRB_DONE = 3'b100
  } mrb_state_type;
endpackage

// ---- design/mrb_backdoor.sv ----
// microcore register backdoor, current measure control and core modes
`timescale 1ns/1ns
module mrb_backdoor (
  input logic mclk,
  input logic reset_n,
  input logic ce,
  input logic [3:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input logic uc_valid,
  input logic [3:0] uc_op,
  input logic [15:0] uc_arg,
  input logic [4:0] output_ownership_rights_hs,
  input logic [6:0] output_ownership_rights_ls,
  input logic [3:0] conv_rights,
  input logic boost_rights,
  input logic target_locked,
  input logic [15:0] cfg_rdata,
  input logic current_zero_fbk,
  output logic [7:0] loc_addr,
  output logic [7:0] cfg_addr,
  output logic [15:0] cfg_wdata,
  output logic [15:0] cfg_wmask,
  output logic cfg_we,
  output logic cfg_re,
  output logic bd_busy,
  output logic [15:0] status_bits,
  output logic [5:0] ofs_comp_apply,
  output logic [1:0] amp_gain,
  output logic adc_mode,
  output logic thr_cmp_en,
  output logic dcdc_en,
  output logic eoa_en,
  output logic eoa_zero_seen,
  output logic [4:0] hs_src_zero
);
  // sequencer and backdoor storage
  mrb_pkg::mrb_state_type state_reg; // backdoor sequencer
  logic [7:0] addr_loc_reg; // backdoor address location
  logic [15:0] data_loc_reg; // backdoor data location
  logic [7:0] cfg_addr_reg; // address sent to register file
  logic [15:0] cfg_wdata_reg; // write data sent
  logic [15:0] cfg_wmask_reg; // writable bits of that write
  logic cfg_we_reg; // one-cycle write strobe
  logic cfg_re_reg; // one-cycle read strobe
  logic busy_reg; // backdoor in progress
  // microcore state
  logic [15:0] status_reg; // status bits
  logic [5:0] oc_apply_reg; // per-converter compensation
  logic [1:0] gain_reg; // shunt amplifier gain
  logic adc_reg; // conversion mode
  logic cmp_en_reg; // threshold comparison enable
  logic dcdc_reg; // converter mode
  logic eoa_reg; // end-of-actuation mode
  logic eoa_auto_reg; // auto zero of source threshold
  logic [2:0] eoa_sel_reg; // high-side chosen for auto zero
  logic eoa_zero_reg; // zero current seen, sticky
  logic [4:0] src_zero_reg; // forced zero source thresholds
  // bus slave
  logic wait_reg; // avalon waitrequest
  logic [31:0] rdata_reg; // avalon read data
  logic [31:0] rd_mux; // read data selected by address
  logic [31:0] ctrl_word; // control readback word
  logic av_wr; // avalon write completes this cycle
  // backdoor issue terms
  logic rd_go; // read instruction accepted
  logic wr_go; // write instruction accepted
  logic rd_ok; // read goes to the register file
  logic wr_ok; // write goes to the register file
  logic [15:0] go_mask; // mask for the target register

  // mask of owned fields, n fields of w bits from bit 0
  function automatic logic [15:0] fld_mask(input logic [6:0] own, input int w, input int n);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 7; i++)
    begin
      if (i < n && own[i])
        m = m | (16'((1 << w) - 1) << (i * w));
    end
    return m;
  endfunction

  // bits of register a that this microcore may change
  function automatic logic [15:0] wr_mask(input logic [7:0] a, input logic [4:0] hs,
                                          input logic [6:0] ls, input logic [3:0] cv,
                                          input logic bo);
    logic [15:0] m;
    m = 16'hffff;
    case (a)
      mrb_pkg::A_HS_DRAIN, mrb_pkg::A_HS_SRC:
        m = fld_mask({2'b00, hs}, mrb_pkg::THR_W, mrb_pkg::NUM_HS);
      mrb_pkg::A_LS_DRAIN_A:
        m = fld_mask(ls, mrb_pkg::THR_W, mrb_pkg::LS_A_N);
      mrb_pkg::A_LS_DRAIN_B:
        m = fld_mask({5'b00000, ls[mrb_pkg::NUM_LS-1:mrb_pkg::LS_A_N]}, mrb_pkg::THR_W,
                     mrb_pkg::NUM_LS - mrb_pkg::LS_A_N);
      mrb_pkg::A_HS_SLEW:
        m = fld_mask({2'b00, hs}, mrb_pkg::SLEW_W, mrb_pkg::NUM_HS);
      mrb_pkg::A_LS_SLEW:
        m = fld_mask(ls, mrb_pkg::SLEW_W, mrb_pkg::NUM_LS);
      mrb_pkg::A_BIAS:
        m = {4'h0, ls, hs};
      mrb_pkg::A_FILT_12:
        m = {{mrb_pkg::FILT_W{cv[1]}}, {mrb_pkg::FILT_W{cv[0]}}};
      mrb_pkg::A_FILT_34L:
        m = {{mrb_pkg::FILT_W{cv[3]}}, {mrb_pkg::FILT_W{cv[2]}}};
      mrb_pkg::A_FILT_4H4NEG:
        m = {16{cv[3]}};
      mrb_pkg::A_BOOST_FILT:
        m = {16{bo}};
      default:
        m = 16'hffff;
    endcase
    return m;
  endfunction

  // converter thresholds and boost threshold are out of reach
  function automatic logic is_blocked(input logic [7:0] a);
    return (a >= mrb_pkg::A_DAC_FIRST && a <= mrb_pkg::A_DAC_LAST) ||
           a == mrb_pkg::A_BOOST_DAC;
  endfunction

  // issue decode; new backdoor requests only when idle
  assign rd_go = uc_valid && uc_op == mrb_pkg::OP_BD_READ && state_reg == mrb_pkg::MRB_IDLE;
  assign wr_go = uc_valid && uc_op == mrb_pkg::OP_BD_WRITE && state_reg == mrb_pkg::MRB_IDLE;
  assign go_mask = wr_mask(addr_loc_reg, output_ownership_rights_hs,
                           output_ownership_rights_ls, conv_rights, boost_rights);
  // lock sampled at issue; rejected writes still load cfg_addr and set busy but never pulse cfg_we
  assign wr_ok = wr_go && !target_locked && !is_blocked(addr_loc_reg) &&
                 go_mask != 16'h0000;
  assign rd_ok = rd_go && !is_blocked(addr_loc_reg);
  assign av_wr = avs_write && !wait_reg;

  // sequencer: issue, transfer, done, idle
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= mrb_pkg::MRB_IDLE;
    else if (ce)
    begin
      case (state_reg)
        mrb_pkg::MRB_IDLE:
          if (rd_go || wr_go)
            state_reg <= mrb_pkg::MRB_XFER;
        mrb_pkg::MRB_XFER:
          state_reg <= mrb_pkg::MRB_DONE;
        mrb_pkg::MRB_DONE:
          state_reg <= mrb_pkg::MRB_IDLE;
        default:
          state_reg <= mrb_pkg::MRB_IDLE;
      endcase
    end
  end

  // busy flag covers the two cycles of an access
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      busy_reg <= 1'b0;
    else if (ce)
    begin
      if (state_reg == mrb_pkg::MRB_IDLE)
        busy_reg <= rd_go || wr_go;
      else
        busy_reg <= state_reg == mrb_pkg::MRB_XFER;
    end
  end

  // register file request, strobes last one cycle
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_addr_reg <= 8'h00;
      cfg_wdata_reg <= 16'h0000;
      cfg_wmask_reg <= 16'h0000;
      cfg_we_reg <= 1'b0;
      cfg_re_reg <= 1'b0;
    end
    else if (ce)
    begin
      cfg_re_reg <= rd_ok;
      cfg_we_reg <= wr_ok;
      if (rd_go || wr_go)
      begin
        cfg_addr_reg <= addr_loc_reg;
        cfg_wdata_reg <= data_loc_reg;
        cfg_wmask_reg <= go_mask;
      end
    end
  end

  // address and data locations; read result wins over loads
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addr_loc_reg <= 8'h00;
      data_loc_reg <= 16'h0000;
    end
    else if (ce)
    begin
      if (cfg_re_reg)
        data_loc_reg <= cfg_rdata;
      else if (uc_valid && uc_op == mrb_pkg::OP_LD_DATA)
        data_loc_reg <= uc_arg;
      else if (av_wr && avs_address == mrb_pkg::R_DATA)
        data_loc_reg <= avs_writedata[15:0];
      // address location is plain storage, loads only
      if (uc_valid && uc_op == mrb_pkg::OP_LD_ADDR)
        addr_loc_reg <= uc_arg[7:0];
      else if (av_wr && avs_address == mrb_pkg::R_ADDR)
        addr_loc_reg <= avs_writedata[7:0];
    end
  end

  // status bits: whole word or single bit, microcode first
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      status_reg <= mrb_pkg::STATUS_RST;
    else if (ce)
    begin
      if (uc_valid && uc_op == mrb_pkg::OP_ST_WORD)
        status_reg <= uc_arg;
      else if (uc_valid && uc_op == mrb_pkg::OP_ST_BIT)
        status_reg[uc_arg[3:0]] <= uc_arg[mrb_pkg::BIT_VAL];
      else if (av_wr && avs_address == mrb_pkg::R_STATUS)
        status_reg <= avs_writedata[15:0];
    end
  end

  // current measure control: compensation, gain, conversion
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oc_apply_reg <= 6'h00;
      gain_reg <= mrb_pkg::GAIN_RST;
      adc_reg <= 1'b0;
      cmp_en_reg <= 1'b1;
    end
    else if (ce && uc_valid)
    begin
      if (uc_op == mrb_pkg::OP_OFS_COMP)
        // four converters plus 4h on the 4l offset, never neg
        oc_apply_reg <= {1'b0, {(mrb_pkg::CONV_N - 1){uc_arg[0]}}};
      if (uc_op == mrb_pkg::OP_GAIN)
        gain_reg <= uc_arg[mrb_pkg::GAIN_W-1:0];
      if (uc_op == mrb_pkg::OP_ADC)
      begin
        adc_reg <= uc_arg[0];
        cmp_en_reg <= !uc_arg[0];
      end
    end
  end

  // converter mode, held only while the converter low-side output is owned
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      dcdc_reg <= 1'b0;
    else if (ce)
    begin
      if (!output_ownership_rights_ls[mrb_pkg::CONV_LS_IDX])
        dcdc_reg <= 1'b0;
      else if (uc_valid && uc_op == mrb_pkg::OP_DCDC)
        dcdc_reg <= uc_arg[0];
    end
  end

  // end-of-actuation mode and automatic source threshold zero
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      eoa_reg <= 1'b0;
      eoa_auto_reg <= 1'b0;
      eoa_sel_reg <= 3'h0;
      src_zero_reg <= 5'h00;
    end
    else if (ce && uc_valid && uc_op == mrb_pkg::OP_EOA)
    begin
      eoa_reg <= uc_arg[0];
      eoa_auto_reg <= uc_arg[mrb_pkg::EOA_AUTO];
      eoa_sel_reg <= uc_arg[mrb_pkg::EOA_SEL_LO+2:mrb_pkg::EOA_SEL_LO];
      // selects above the last high-side shift out to no force
      if (uc_arg[0] && uc_arg[mrb_pkg::EOA_AUTO])
        src_zero_reg <= 5'h01 << uc_arg[mrb_pkg::EOA_SEL_LO+2:mrb_pkg::EOA_SEL_LO];
      else
        src_zero_reg <= 5'h00;
    end
  end

  // zero current detect, sticky; a set beats any clear
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      eoa_zero_reg <= 1'b0;
    else if (ce)
    begin
      if (eoa_reg && current_zero_fbk)
        eoa_zero_reg <= 1'b1;
      else if (uc_valid && uc_op == mrb_pkg::OP_EOA && uc_arg[0])
        eoa_zero_reg <= 1'b0;
      else if (av_wr && avs_address == mrb_pkg::R_CTRL && avs_writedata[mrb_pkg::CTRL_CLR_ZERO])
        eoa_zero_reg <= 1'b0;
    end
  end

  // control readback word
  assign ctrl_word = {20'h00000, busy_reg, eoa_zero_reg, eoa_sel_reg, eoa_auto_reg,
                      eoa_reg, dcdc_reg, adc_reg, gain_reg, oc_apply_reg[0]};

  // read data by byte address, unmapped reads zero
  always_comb
  begin
    case (avs_address)
      mrb_pkg::R_ADDR: rd_mux = {24'h000000, addr_loc_reg};
      mrb_pkg::R_DATA: rd_mux = {16'h0000, data_loc_reg};
      mrb_pkg::R_STATUS: rd_mux = {16'h0000, status_reg};
      mrb_pkg::R_CTRL: rd_mux = ctrl_word;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // avalon slave: one wait cycle, then one answer cycle
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end
    else if (ce)
    begin
      if (wait_reg && (avs_read || avs_write))
      begin
        wait_reg <= 1'b0;
        rdata_reg <= rd_mux;
      end
      else
        wait_reg <= 1'b1;
    end
  end

  // outputs straight from flops
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign loc_addr = addr_loc_reg;
  assign cfg_addr = cfg_addr_reg;
  assign cfg_wdata = cfg_wdata_reg;
  assign cfg_wmask = cfg_wmask_reg;
  assign cfg_we = cfg_we_reg;
  assign cfg_re = cfg_re_reg;
  assign bd_busy = busy_reg;
  assign status_bits = status_reg;
  assign ofs_comp_apply = oc_apply_reg;
  assign amp_gain = gain_reg;
  assign adc_mode = adc_reg;
  assign thr_cmp_en = cmp_en_reg;
  assign dcdc_en = dcdc_reg;
  assign eoa_en = eoa_reg;
  assign eoa_zero_seen = eoa_zero_reg;
  assign hs_src_zero = src_zero_reg;

  // checks on the backdoor and the modes
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n || !ce);

  a_read_two_cycle: assert property (rd_ok |=> cfg_re_reg && busy_reg ##1
                                     !cfg_re_reg && busy_reg ##1 !busy_reg)
    else $error("backdoor read did not finish in two cycles");
  a_read_returns: assert property (cfg_re_reg |=> data_loc_reg == $past(cfg_rdata))
    else $error("read result not in data location");
  a_write_issue: assert property (wr_ok |=> cfg_we_reg && cfg_wdata_reg == $past(data_loc_reg)
                                  && cfg_addr_reg == $past(addr_loc_reg))
    else $error("backdoor write not issued");
  a_write_locked: assert property (wr_go && target_locked |=> !cfg_we_reg [*3])
    else $error("write to locked register issued");
  a_blocked_none: assert property ((cfg_we_reg || cfg_re_reg) |-> !is_blocked(cfg_addr_reg))
    else $error("blocked register reached");
  a_mask_owned: assert property (cfg_we_reg |-> cfg_wmask_reg == $past(go_mask))
    else $error("write mask not from ownership");
  a_mask_bias: assert property (cfg_we_reg && cfg_addr_reg == mrb_pkg::A_BIAS |->
                                cfg_wmask_reg[15:12] == 4'h0)
    else $error("bias mask beyond pre-drivers");
  a_dcdc_rights: assert property (dcdc_reg |->
                                  $past(output_ownership_rights_ls[mrb_pkg::CONV_LS_IDX]))
    else $error("converter mode without low-side output rights");
  a_adc_no_cmp: assert property (adc_reg |-> !cmp_en_reg)
    else $error("comparison enabled in conversion mode");
  a_ofs_neg_off: assert property (!oc_apply_reg[mrb_pkg::CONV_NEG] &&
                    oc_apply_reg[mrb_pkg::CONV_4H] == oc_apply_reg[mrb_pkg::CONV_4L])
    else $error("negative converter compensated");
  a_status_bit: assert property (uc_valid && uc_op == mrb_pkg::OP_ST_BIT |=>
                    (status_reg ^ $past(status_reg)) == 16'h0000 ||
                    $onehot(status_reg ^ $past(status_reg)))
    else $error("status bit write touched several bits");
  a_eoa_detect: assert property (eoa_reg && current_zero_fbk |=> eoa_zero_reg)
    else $error("zero current not flagged");
  a_eoa_force: assert property (src_zero_reg != 5'h00 |-> eoa_reg && eoa_auto_reg)
    else $error("source threshold forced outside mode");

  c_read: cover property (rd_ok ##1 cfg_re_reg ##2 !busy_reg);
  c_write: cover property (wr_ok ##1 cfg_we_reg);
  c_locked: cover property (wr_go && target_locked);
  c_bus_read: cover property (avs_read && !wait_reg);
endmodule

// ---- test/mrb_cfg_model.sv ----
// behavioural model of the device register file behind the backdoor
`timescale 1ns/1ns
module mrb_cfg_model #(
  parameter logic [7:0] LOCK_A = 8'h20 // locked register, arbitrary choice
) (
  input logic mclk,
  input logic reset_n,
  input logic [7:0] loc_addr,
  input logic [7:0] cfg_addr,
  input logic [15:0] cfg_wdata,
  input logic [15:0] cfg_wmask,
  input logic cfg_we,
  input logic cfg_re,
  output logic [15:0] cfg_rdata,
  output logic target_locked
);
  logic [15:0] mem [0:255]; // register contents, all zero after reset
  logic [15:0] last_reg; // last value answered
  // masked write, only bits with mask one change
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 256; i++)
        mem[i] <= 16'h0000;
    end
    else if (cfg_we)
      mem[cfg_addr] <= (mem[cfg_addr] & ~cfg_wmask) | (cfg_wdata & cfg_wmask);
  end
  // remember the last answer so an idle bus shows its inverse
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      last_reg <= 16'h0000;
    else if (cfg_re)
      last_reg <= cfg_rdata;
  end
  // same-cycle answer while read strobe is high
  assign cfg_rdata = cfg_re ? mem[cfg_addr] : ~last_reg;
  // lock of the register named by the address location
  assign target_locked = (loc_addr == LOCK_A);
endmodule

// ---- test/tb.sv ----
// self-checking bench for the microcore register backdoor
`timescale 1ns/1ns
module tb;
  logic mclk = 1'b0, reset_n = 1'b0, ce = 1'b1;
  logic [3:0] avs_address = 4'h0, uc_op = 4'h0, conv_rights = 4'h2;
  logic avs_read = 1'b0, avs_write = 1'b0, uc_valid = 1'b0, boost_rights = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, target_locked, current_zero_fbk = 1'b0;
  logic [15:0] uc_arg = 16'h0, cfg_rdata, cfg_wdata, cfg_wmask, status_bits;
  logic [4:0] hs_rights = 5'h03, hs_src_zero;
  logic [6:0] ls_rights = 7'h01;
  logic [7:0] loc_addr, cfg_addr;
  logic cfg_we, cfg_re, bd_busy, adc_mode, thr_cmp_en, dcdc_en, eoa_en, eoa_zero_seen;
  logic [5:0] ofs_comp_apply;
  logic [1:0] amp_gain;
  int miscompares = 0, comparisons = 0;
  // filtered registers and readback after writing all ones
  logic [7:0] ta [6] = '{8'h8a, 8'h8e, 8'h8f, 8'ha0, 8'ha1, 8'h9d};
  logic [15:0] te [6] = '{16'h003f, 16'h000f, 16'h0003, 16'h0023, 16'hff00, 16'h0000};
  always #5 mclk = ~mclk;
  mrb_backdoor dut_u (.mclk(mclk), .reset_n(reset_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .uc_valid(uc_valid),
    .uc_op(uc_op), .uc_arg(uc_arg), .output_ownership_rights_hs(hs_rights),
    .output_ownership_rights_ls(ls_rights), .conv_rights(conv_rights),
    .boost_rights(boost_rights), .target_locked(target_locked), .cfg_rdata(cfg_rdata),
    .current_zero_fbk(current_zero_fbk), .loc_addr(loc_addr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_wmask(cfg_wmask), .cfg_we(cfg_we), .cfg_re(cfg_re),
    .bd_busy(bd_busy), .status_bits(status_bits), .ofs_comp_apply(ofs_comp_apply),
    .amp_gain(amp_gain), .adc_mode(adc_mode), .thr_cmp_en(thr_cmp_en), .dcdc_en(dcdc_en),
    .eoa_en(eoa_en), .eoa_zero_seen(eoa_zero_seen), .hs_src_zero(hs_src_zero));
  mrb_cfg_model model_u (.mclk(mclk), .reset_n(reset_n), .loc_addr(loc_addr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wmask(cfg_wmask), .cfg_we(cfg_we),
    .cfg_re(cfg_re), .cfg_rdata(cfg_rdata), .target_locked(target_locked));
  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
      miscompares++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // one microcore instruction, then let its edge land
  task automatic uc(input logic [3:0] op, input logic [15:0] arg);
    @(posedge mclk);
    uc_valid <= 1'b1;
    uc_op <= op;
    uc_arg <= arg;
    @(posedge mclk);
    uc_valid <= 1'b0;
    #1;
  endtask
  // backdoor access, busy exactly two cycles
  task automatic bd(input logic [3:0] op, input logic [7:0] a);
    uc(mrb_pkg::OP_LD_ADDR, {8'h00, a});
    uc(op, 16'h0000); // address location untouched while busy; a read loads the data location
    chk("busy c1", 1, bd_busy);
    @(posedge mclk);
    #1;
    chk("busy c2", 1, bd_busy);
    @(posedge mclk);
    #1;
    chk("busy c3", 0, bd_busy);
  endtask
  initial
  begin
    #200000;
    miscompares++;
    summarize();
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk("thr_cmp reset", 1, thr_cmp_en);
    av(0, mrb_pkg::R_CTRL, 0);
    chk("ctrl reset", 0, rd);
    // spare storage over the bus and by load
    av(1, mrb_pkg::R_ADDR, 32'h5a);
    av(0, mrb_pkg::R_ADDR, 0);
    chk("addr loc", 32'h5a, rd);
    uc(mrb_pkg::OP_LD_DATA, 16'hc3c3);
    av(0, mrb_pkg::R_DATA, 0);
    chk("data loc", 32'hc3c3, rd);
    // write, overwrite data location, read back
    bd(mrb_pkg::OP_BD_WRITE, 8'h10);
    uc(mrb_pkg::OP_LD_DATA, 16'h0000);
    bd(mrb_pkg::OP_BD_READ, 8'h10);
    av(0, mrb_pkg::R_DATA, 0);
    chk("bd readback", 32'hc3c3, rd);
    // locked target keeps its value
    uc(mrb_pkg::OP_LD_DATA, 16'h5555);
    bd(mrb_pkg::OP_BD_WRITE, 8'h20);
    bd(mrb_pkg::OP_BD_READ, 8'h20);
    av(0, mrb_pkg::R_DATA, 0);
    chk("locked", 0, rd);
    // ownership filtered registers
    for (int i = 0; i < 6; i++)
    begin
      uc(mrb_pkg::OP_LD_DATA, 16'hffff);
      bd(mrb_pkg::OP_BD_WRITE, ta[i]);
      bd(mrb_pkg::OP_BD_READ, ta[i]);
      av(0, mrb_pkg::R_DATA, 0);
      chk("filtered", {16'h0, te[i]}, rd);
    end
    // converter threshold unreachable
    av(1, mrb_pkg::R_DATA, 32'hbeef);
    bd(mrb_pkg::OP_BD_READ, 8'h40);
    av(0, mrb_pkg::R_DATA, 0);
    chk("blocked read", 32'hbeef, rd);
    // status word and single bits
    uc(mrb_pkg::OP_ST_WORD, 16'ha5a5);
    uc(mrb_pkg::OP_ST_BIT, 16'h0000);
    chk("status bit0", 32'ha5a4, status_bits);
    uc(mrb_pkg::OP_ST_BIT, 16'h001e);
    chk("status bit14", 32'he5a4, status_bits);
    // current measure controls
    uc(mrb_pkg::OP_OFS_COMP, 16'h0001);
    chk("ofs on", 32'h1f, ofs_comp_apply);
    uc(mrb_pkg::OP_GAIN, 16'h0002);
    chk("gain", 2, amp_gain);
    uc(mrb_pkg::OP_ADC, 16'h0001);
    chk("adc", 1, adc_mode);
    chk("no compare", 0, thr_cmp_en);
    av(0, mrb_pkg::R_CTRL, 0);
    chk("ctrl", 32'h0d, rd);
    uc(mrb_pkg::OP_OFS_COMP, 16'h0000);
    chk("ofs off", 0, ofs_comp_apply);
    // converter mode needs the converter low-side output
    uc(mrb_pkg::OP_DCDC, 16'h0001);
    chk("dcdc refused", 0, dcdc_en);
    @(posedge mclk);
    ls_rights <= 7'h41;
    uc(mrb_pkg::OP_DCDC, 16'h0001);
    chk("dcdc on", 1, dcdc_en);
    @(posedge mclk);
    ls_rights <= 7'h01;
    @(posedge mclk);
    @(posedge mclk);
    #1;
    chk("dcdc dropped", 0, dcdc_en);
    // end of actuation with automatic source threshold on hs3
    uc(mrb_pkg::OP_EOA, 16'h000b);
    chk("src zero", 32'h04, hs_src_zero);
    chk("eoa on", 1, eoa_en);
    @(posedge mclk);
    current_zero_fbk <= 1'b1;
    @(posedge mclk);
    current_zero_fbk <= 1'b0;
    @(posedge mclk);
    #1;
    chk("zero seen", 1, eoa_zero_seen);
    av(1, mrb_pkg::R_CTRL, 32'h400);
    av(0, mrb_pkg::R_CTRL, 0);
    chk("zero cleared", 0, rd[10]);
    uc(mrb_pkg::OP_EOA, 16'h0000);
    chk("src released", 0, hs_src_zero);
    summarize();
  end
endmodule
